/* File: core/utsb_pkg.sv */
// Package for the transmit status and baud generator block.
// Assumes an 8-bit register port addressed by 16-bit byte addresses.
package utsb_pkg;
  // ==========================================================
  // Register map
  localparam logic [15:0] ADDR_MODE = 16'hFF50;
  localparam logic [15:0] ADDR_TXBUF = 16'hFF51;
  localparam logic [15:0] ADDR_TX_STATUS = 16'hFF55;
  localparam logic [15:0] ADDR_BASE_CLK_SEL = 16'hFF56;
  localparam logic [15:0] ADDR_BAUD_DIV = 16'hFF57;
  localparam logic [15:0] ADDR_SER_CTRL = 16'hFF58;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_TX_STATUS = 8'h00;
  localparam logic [7:0] RST_BASE_CLK_SEL = 8'h00;
  localparam logic [7:0] RST_BAUD_DIV = 8'hFF;
  localparam logic [7:0] RST_SER_CTRL = 8'h16;
  // ==========================================================
  // Field positions
  localparam int BIT_POWER = 7;
  localparam int BIT_TX_EN = 6;
  localparam int BIT_RX_EN = 5;
  localparam int BIT_BUF_FULL = 1;
  localparam int BIT_SHIFT_ACT = 0;
  localparam int BIT_BREAK_TRIG = 6;
  localparam logic [7:0] SER_CTRL_WMASK = 8'h43;
  localparam logic [3:0] CODE_MAX_DIV = 4'hA;
  localparam logic [3:0] CODE_TIMER = 4'hB;
  localparam logic [7:0] DIV_MIN = 8'h08;
  localparam logic [3:0] CHAR_BITS = 4'hA;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} utsb_tx_state_type;
endpackage

/* File: core/utsb_baud_div.sv */
// Baud tick generator: base clock select, 8-bit divide, halving.
// Assumes timer input already synchronised to clock.
`timescale 1ns/1ns
`default_nettype none
module utsb_baud_div
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [3:0] baseCode,
  input wire logic [7:0] divisor,
  input wire logic timerOut,
  output logic baudTick
);
  import utsb_pkg::*;
  logic [10:0] prescaleReg;
  logic [10:0] prescaleNext;
  logic timerPrevReg;
  logic baseTick;
  logic [7:0] countReg;
  logic halfReg;
  logic divTick;
  // ==========================================================
  // Base clock
  assign prescaleNext = prescaleReg + 11'h001;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prescaleReg <= 11'h000;
    else if (!run)
      prescaleReg <= 11'h000;
    else
      prescaleReg <= prescaleNext;
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      timerPrevReg <= 1'b0;
    else
      timerPrevReg <= timerOut;
  end
  // Tick once per 2^code clocks; codes above the timer are inert
  always_comb
  begin
    if (baseCode == CODE_TIMER)
      baseTick = timerOut & ~timerPrevReg;
    else if (baseCode > CODE_MAX_DIV)
      baseTick = 1'b0;
    else
      baseTick = ((prescaleNext & ((11'h001 << baseCode) - 11'h001)) == 11'h000);
  end
  // ==========================================================
  // Divide by k, then by 2
  assign divTick = baseTick && (countReg >= divisor - 8'h01) && (divisor >= DIV_MIN);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      countReg <= 8'h00;
    else if (!run)
      countReg <= 8'h00;
    else if (divTick)
      countReg <= 8'h00;
    else if (baseTick)
      countReg <= countReg + 8'h01;
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halfReg <= 1'b0;
      baudTick <= 1'b0;
    end
    else if (!run)
    begin
      halfReg <= 1'b0;
      baudTick <= 1'b0;
    end
    else
    begin
      if (divTick)
        halfReg <= ~halfReg;
      baudTick <= divTick & halfReg;
    end
  end
endmodule
`default_nettype wire

/* File: core/utsb_top.sv */
// Transmit status flags, base clock select, baud divisor, control regs.
// Assumes a same-clock CPU port; timer output arrives from another domain.
// How it works
// - Buffer-full set by buffer write, cleared on move to shifter or disable
// - Shift-active set on move to shifter, cleared at end with nothing pending
// - Status reads 8 bits, upper six zero, cleared when power or enable off
// - Buffer accepts next byte once previous moved, giving gapless characters
// - Base clock is main clock over 2^code for 0..10, code 11 timer
// - Divisor k from 8 to 255 divides base clock by k
// - Baud rate is divider output halved
// - Reset loads divisor FFH and base clock select 00H
// - Same-value write to base clock select never disturbs traffic
// - Serial control resets to 16H
// - Break trigger self-clears at completion; a write of one while pending does not restart it
// - Power off stops clock and resets unit including both flags
// - Break trigger always reads back zero
`timescale 1ns/1ns
`default_nettype none
module utsb_top
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic timerPin,
  input wire logic breakDone,
  output logic txLine,
  output logic txDoneIrq,
  output logic breakRxStart
);
  import utsb_pkg::*;

  logic [7:0] modeReg;
  logic [7:0] baseClkReg;
  logic [7:0] divisorReg;
  logic [7:0] ctrlReg;
  logic breakTrigReg;
  logic [7:0] txBufReg;
  logic [9:0] shiftReg;
  logic [3:0] bitCntReg;
  logic bufFullReg;
  logic shiftActReg;
  utsb_tx_state_type stateReg;
  logic timerMetaReg;
  logic timerSyncReg;
  logic baudTick;
  logic powerOn;
  logic txOn;
  logic txRun;
  logic loadShift;
  logic charEnd;
  logic charDone;
  logic wrMode;
  logic wrBaseClk;
  logic wrDivisor;
  logic wrCtrl;
  logic wrTxBuf;

  // ==========================================================
  // Decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction
  // Write strobes, one per writable register
  assign wrMode = regWrite && hit(regAddr, ADDR_MODE);
  assign wrBaseClk = regWrite && hit(regAddr, ADDR_BASE_CLK_SEL);
  assign wrDivisor = regWrite && hit(regAddr, ADDR_BAUD_DIV);
  assign wrCtrl = regWrite && hit(regAddr, ADDR_SER_CTRL);
  assign wrTxBuf = regWrite && hit(regAddr, ADDR_TXBUF);
  assign powerOn = modeReg[BIT_POWER];
  assign txOn = powerOn && modeReg[BIT_TX_EN];
  assign txRun = (stateReg == TX_SHIFT);
  assign charEnd = (bitCntReg == CHAR_BITS - 4'h1);
  assign charDone = txRun && charEnd && baudTick;
  // Loads wait for a baud tick so the start bit is a full bit long
  assign loadShift = txOn && bufFullReg && baudTick && (!txRun || charEnd);

  // ==========================================================
  // Timer input synchroniser
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timerMetaReg <= 1'b0;
      timerSyncReg <= 1'b0;
    end
    else
    begin
      timerMetaReg <= timerPin;
      timerSyncReg <= timerMetaReg;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      modeReg <= RST_MODE;
    else if (wrMode)
      modeReg <= regWdata;
  end

  // Same-value writes change nothing, so refresh is harmless
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      baseClkReg <= RST_BASE_CLK_SEL;
    else if (wrBaseClk)
      baseClkReg <= {4'h0, regWdata[3:0]};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      divisorReg <= RST_BAUD_DIV;
    else if (wrDivisor)
      divisorReg <= regWdata;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ctrlReg <= RST_SER_CTRL;
    else if (wrCtrl)
      ctrlReg <= (RST_SER_CTRL & ~SER_CTRL_WMASK) | (regWdata & SER_CTRL_WMASK & 8'h03);
  end

  // Break trigger: write of one starts, completion or power-off clears
  // A write while a break is still pending does not restart it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      breakTrigReg <= 1'b0;
      breakRxStart <= 1'b0;
    end
    else
    begin
      breakRxStart <= 1'b0;
      if (!powerOn)
        breakTrigReg <= 1'b0;
      else if (wrCtrl && regWdata[BIT_BREAK_TRIG])
      begin
        breakTrigReg <= 1'b1;
        breakRxStart <= !breakTrigReg || breakDone;
      end
      else if (breakDone)
        breakTrigReg <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit buffer and status flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      txBufReg <= 8'h00;
    else if (wrTxBuf && txOn)
      txBufReg <= regWdata;
  end

  // A write in the cycle of the transfer re-fills the buffer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bufFullReg <= 1'b0;
    else if (!txOn)
      bufFullReg <= 1'b0;
    else if (wrTxBuf)
      bufFullReg <= 1'b1;
    else if (loadShift)
      bufFullReg <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      shiftActReg <= 1'b0;
    else if (!txOn)
      shiftActReg <= 1'b0;
    else if (loadShift)
      shiftActReg <= 1'b1;
    else if (charDone)
      shiftActReg <= 1'b0;
  end

  // ==========================================================
  // Shifter: start, eight data bits LSB first, stop
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= TX_IDLE;
      shiftReg <= 10'h3FF;
      bitCntReg <= 4'h0;
    end
    else if (!txOn)
    begin
      stateReg <= TX_IDLE;
      shiftReg <= 10'h3FF;
      bitCntReg <= 4'h0;
    end
    else
    begin
      case (stateReg)
        TX_IDLE:
        begin
          if (loadShift)
          begin
            stateReg <= TX_SHIFT;
            shiftReg <= {1'b1, txBufReg, 1'b0};
            bitCntReg <= 4'h0;
          end
        end
        TX_SHIFT:
        begin
          // Last tick of a stop bit loads the next frame with no idle gap
          if (loadShift)
          begin
            shiftReg <= {1'b1, txBufReg, 1'b0};
            bitCntReg <= 4'h0;
          end
          else if (baudTick && charEnd)
            stateReg <= TX_IDLE;
          else if (baudTick)
          begin
            shiftReg <= {1'b1, shiftReg[9:1]};
            bitCntReg <= bitCntReg + 4'h1;
          end
        end
        default:
          stateReg <= TX_IDLE;
      endcase
    end
  end

  // Line idles high while powered off
  // Gated by txOn so the line rises on the same edge as the flags clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      txLine <= 1'b1;
    else
      txLine <= (txRun && txOn) ? shiftReg[0] : 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      txDoneIrq <= 1'b0;
    else
      txDoneIrq <= txOn && charDone && !bufFullReg;
  end

  // ==========================================================
  // Read port
  // Data stand one cycle for each cycle of regRead; every other cycle returns zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (!regRead)
      regRdata <= 8'h00;
    else if (hit(regAddr, ADDR_TX_STATUS))
      regRdata <= {6'h00, bufFullReg, shiftActReg};
    else if (hit(regAddr, ADDR_MODE))
      regRdata <= modeReg;
    else if (hit(regAddr, ADDR_BASE_CLK_SEL))
      regRdata <= baseClkReg;
    else if (hit(regAddr, ADDR_BAUD_DIV))
      regRdata <= divisorReg;
    else if (hit(regAddr, ADDR_SER_CTRL))
      regRdata <= ctrlReg;
    else
      regRdata <= 8'h00;
  end

  // ==========================================================
  // Baud generator; stopped and cleared while power is off
  utsb_baud_div u_baud
  (
    .clock(clock),
    .rst_n(rst_n),
    .run(powerOn),
    .baseCode(baseClkReg[3:0]),
    .divisor(divisorReg),
    .timerOut(timerSyncReg),
    .baudTick(baudTick)
  );
endmodule
`default_nettype wire

/* File: dv/utsb_asserts.sv */
// Checker on the utsb_top ports.
// Assumes one clock domain; keeps copies of the mode register and break trigger.
`timescale 1ns/1ns
`default_nettype none
module utsb_asserts
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic timerPin,
  input wire logic breakDone,
  input wire logic txLine,
  input wire logic txDoneIrq,
  input wire logic breakRxStart
);
  import utsb_pkg::*;
  logic [7:0] modeCopy_reg;
  logic trigCopy_reg;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Mode copy
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      modeCopy_reg <= RST_MODE;
    else if (regWrite && regAddr == ADDR_MODE)
      modeCopy_reg <= regWdata;
  end
  // Pending break: set by a trigger write, cleared by completion or power-off
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      trigCopy_reg <= 1'b0;
    else if (!modeCopy_reg[BIT_POWER])
      trigCopy_reg <= 1'b0;
    else if (regWrite && regAddr == ADDR_SER_CTRL && regWdata[BIT_BREAK_TRIG])
      trigCopy_reg <= 1'b1;
    else if (breakDone)
      trigCopy_reg <= 1'b0;
  end
  // ==========================================================
  // Sequences
  sequence readCtrl;
    regRead && regAddr == ADDR_SER_CTRL;
  endsequence
  sequence trigWrite;
    regWrite && regAddr == ADDR_SER_CTRL && regWdata[BIT_BREAK_TRIG]
      && modeCopy_reg[BIT_POWER] && (!trigCopy_reg || breakDone);
  endsequence
  // ==========================================================
  // Properties
  a_status_upper: assert property (regRead && regAddr == ADDR_TX_STATUS
    |=> regRdata[7:2] == 6'h00) else $error("status upper bits set");
  a_off_status: assert property (regRead && regAddr == ADDR_TX_STATUS
    && !modeCopy_reg[BIT_TX_EN] && !$past(modeCopy_reg[BIT_TX_EN])
    |=> regRdata == 8'h00) else $error("status not clear while disabled");
  a_trig_reads0: assert property (readCtrl |=> !regRdata[6])
    else $error("break trigger read as one");
  a_ctrl_fixed: assert property (readCtrl |=> regRdata[5:2] == 4'h5)
    else $error("control fixed bits wrong");
  a_break_start: assert property (trigWrite |=> breakRxStart)
    else $error("break start missing");
  a_break_only: assert property (!(regWrite && regAddr == ADDR_SER_CTRL)
    |=> !breakRxStart) else $error("break start without control write");
  a_irq_idle: assert property (txDoneIrq |-> txLine)
    else $error("completion while line low");
  // Even the fastest legal setting gives 16 clocks per bit
  a_start_min: assert property ($fell(txLine) |-> !txLine [*8])
    else $error("start bit too short");
  a_off_quiet: assert property (!modeCopy_reg[BIT_POWER] |=> txLine)
    else $error("line low while unpowered");
endmodule
bind utsb_top utsb_asserts uChk
(
  .clock(clock),
  .rst_n(rst_n),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWrite(regWrite),
  .regRead(regRead),
  .regRdata(regRdata),
  .timerPin(timerPin),
  .breakDone(breakDone),
  .txLine(txLine),
  .txDoneIrq(txDoneIrq),
  .breakRxStart(breakRxStart)
);
`default_nettype wire

/* File: dv/utsb_remote_node.sv */
// Remote serial node: decodes frames seen on the line.
// Assumes bitLen holds the clocks per bit that the bench set up.
`timescale 1ns/1ns
`default_nettype none
module utsb_remote_node
(
  input wire logic clock,
  input wire logic txLine,
  input wire logic [15:0] bitLen,
  output logic [7:0] rxByte,
  output logic [7:0] rxCount,
  output logic [15:0] span
);
  time t0;
  // Only frames with a good stop bit are counted
  initial
  begin
    rxCount = 8'h00;
    rxByte = 8'h00;
    span = 16'h0000;
    t0 = 0;
    forever
    begin
      @(negedge txLine);
      span = 16'(($time - t0) / 50);
      t0 = $time;
      repeat (bitLen / 2) @(posedge clock);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bitLen) @(posedge clock);
        rxByte[i] = txLine;
      end
      repeat (bitLen) @(posedge clock);
      if (txLine)
        rxCount = rxCount + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Testbench: register port tasks and call sequences with expectations.
// Assumes the remote node model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import utsb_pkg::*;
  logic clock, rst_n, regWrite, regRead, timerPin, breakDone, txLine, txDoneIrq, breakRxStart;
  logic [15:0] regAddr, bitLen, span, p;
  logic [7:0] regWdata, regRdata, rxByte, rxCount, v, n0;
  logic [1:0] tc;
  int fail_count, check_count, t;
  logic [15:0] ra [5] = '{16'hFF55, 16'hFF56, 16'hFF57, 16'hFF58, 16'hFF59};
  logic [7:0] re [5] = '{8'h00, 8'h00, 8'hFF, 8'h16, 8'h00};
  logic [3:0] bc [5] = '{4'h0, 4'h1, 4'h3, 4'h0, 4'hB};
  logic [7:0] bk [5] = '{8'h08, 8'h09, 8'h0A, 8'hFF, 8'h08};
  utsb_top uut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .timerPin(timerPin),
    .breakDone(breakDone), .txLine(txLine), .txDoneIrq(txDoneIrq),
    .breakRxStart(breakRxStart));
  utsb_remote_node node (.clock(clock), .txLine(txLine), .bitLen(bitLen),
    .rxByte(rxByte), .rxCount(rxCount), .span(span));
  // ==========================================================
  // Clock and timer
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Square wave of four clocks, half high and half low
  always @(posedge clock)
  begin
    tc <= tc + 2'h1;
    timerPin <= tc[1];
  end
  // ==========================================================
  // Tasks
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic waitOn(input bit irq, input logic lv, output int n);
    n = 0;
    while ((irq ? txDoneIrq : txLine) !== lv)
    begin
      @(posedge clock);
      #1 n++;
      if (n > 8000)
      begin
        fail_count++;
        $display("ERROR %0t wait timed out", $time);
        wrap_up();
      end
    end
  endtask
  // Baud settings are only changed with the unit stopped
  task automatic cfg(input logic [3:0] c, input logic [7:0] k, input logic [15:0] bl);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_BASE_CLK_SEL, {4'h0, c});
    wr(ADDR_BAUD_DIV, k);
    wr(ADDR_MODE, 8'h80);
    wr(ADDR_MODE, 8'hC0);
    bitLen <= bl;
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    {rst_n, regWrite, regRead, breakDone, timerPin, tc} = '0;
    {regAddr, regWdata, bitLen} = '0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i], v);
      chk(v, re[i]);
    end
    wr(ADDR_TX_STATUS, 8'hFF);
    rd(ADDR_TX_STATUS, v);
    chk(v, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      p = (bc[i] == 4'hB) ? 16'h0008 * bk[i] : (16'h0002 * bk[i]) << bc[i];
      cfg(bc[i], bk[i], p);
      wr(ADDR_TXBUF, 8'hFF);
      waitOn(1'b0, 1'b0, t);
      waitOn(1'b0, 1'b1, t);
      chk(16'(t), p);
      waitOn(1'b1, 1'b1, t);
    end
    cfg(4'h0, 8'h08, 16'h0010);
    n0 = rxCount;
    wr(ADDR_TXBUF, 8'hA5);
    t = 0;
    do
    begin
      rd(ADDR_TX_STATUS, v);
      t++;
    end
    while (v[1] !== 1'b0 && t < 50);
    chk(v, 8'h01);
    wr(ADDR_BASE_CLK_SEL, 8'h00);
    wr(ADDR_TXBUF, 8'h3C);
    rd(ADDR_TX_STATUS, v);
    chk(v, 8'h03);
    waitOn(1'b1, 1'b1, t);
    rd(ADDR_TX_STATUS, v);
    chk(v, 8'h00);
    chk(rxByte, 8'h3C);
    chk(rxCount, n0 + 8'h02);
    chk(span, 16'h00A0);
    wr(ADDR_TXBUF, 8'h5A);
    waitOn(1'b0, 1'b0, t);
    wr(ADDR_TXBUF, 8'hC3);
    repeat (20) @(posedge clock);
    rd(ADDR_TX_STATUS, v);
    chk(v, 8'h03);
    wr(ADDR_MODE, 8'h80);
    rd(ADDR_TX_STATUS, v);
    chk(v, 8'h00);
    wr(ADDR_TXBUF, 8'h11);
    rd(ADDR_TX_STATUS, v);
    chk(v, 8'h00);
    repeat (200) @(posedge clock);
    wr(ADDR_MODE, 8'hA0);
    wr(ADDR_SER_CTRL, 8'h56);
    #1 chk(16'(breakRxStart), 16'h0001);
    rd(ADDR_SER_CTRL, v);
    chk(v, 8'h16);
    wr(ADDR_SER_CTRL, 8'h56);
    #1 chk(16'(breakRxStart), 16'h0000);
    @(posedge clock);
    breakDone <= 1'b1;
    @(posedge clock);
    breakDone <= 1'b0;
    wr(ADDR_SER_CTRL, 8'h56);
    #1 chk(16'(breakRxStart), 16'h0001);
    wr(ADDR_MODE, 8'h00);
    rd(ADDR_TX_STATUS, v);
    chk(v, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
